// >>> hw/fwsr_bus_cycle.sv
`timescale 1ns/10ps
// ======================================================================
// One asynchronous read or write cycle on the flash pins
module fwsr_bus_cycle import fwsr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_write,
  input wire logic frame_cs,
  input wire logic [FLASH_AW-1:0] addr,
  input wire logic [FLASH_DW-1:0] wdata,
  input wire logic [FLASH_DW-1:0] data_sync,
  output logic done,
  output logic [FLASH_DW-1:0] rdata,
  output logic [FLASH_AW-1:0] flash_addr,
  output logic flash_chip_select_n,
  output logic flash_read_strobe_n,
  output logic flash_write_strobe_n,
  output logic [FLASH_DW-1:0] flash_data_out,
  output logic flash_data_oe_n
);

  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_RECOVER} fwsr_bus_t;

  fwsr_bus_t state_q;
  logic [3:0] cnt_q;
  logic wr_q;
  logic cs_frame_q;
  wire cnt_zero = (cnt_q == 4'h0);

  // ======================================================================
  // Cycle sequencer; pins are flops so no glitch reaches the flash
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= B_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      cs_frame_q <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      flash_addr <= '0;
      flash_chip_select_n <= 1'b1;
      flash_read_strobe_n <= 1'b1;
      flash_write_strobe_n <= 1'b1;
      flash_data_out <= 8'h00;
      flash_data_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_q)
        B_IDLE: begin
          if (start) begin
            state_q <= B_SETUP;
            cnt_q <= SETUP_CNT;
            wr_q <= is_write;
            cs_frame_q <= frame_cs && !is_write;
            flash_addr <= addr;
            flash_data_out <= wdata;
            flash_data_oe_n <= !is_write;
            // Select framing: strobe first, select last
            flash_chip_select_n <= frame_cs && !is_write;
            flash_read_strobe_n <= !(frame_cs && !is_write);
          end
        end
        B_SETUP: begin
          if (cnt_zero) begin
            state_q <= B_STROBE;
            cnt_q <= wr_q ? WR_STROBE_CNT : RD_STROBE_CNT;
            flash_chip_select_n <= 1'b0;
            flash_read_strobe_n <= wr_q;
            flash_write_strobe_n <= !wr_q;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        B_STROBE: begin
          if (cnt_zero) begin
            state_q <= B_RECOVER;
            rdata <= data_sync;
            flash_write_strobe_n <= 1'b1;
            // One rising edge ends the read: select or strobe
            flash_chip_select_n <= cs_frame_q && !wr_q;
            flash_read_strobe_n <= !cs_frame_q || wr_q;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        B_RECOVER: begin
          // Data held one cycle past the write strobe for hold time
          state_q <= B_IDLE;
          done <= 1'b1;
          flash_chip_select_n <= 1'b1;
          flash_read_strobe_n <= 1'b1;
          flash_data_oe_n <= 1'b1;
        end
        default: state_q <= B_IDLE;
      endcase
    end
  end

endmodule : fwsr_bus_cycle

// >>> hw/fwsr_host.sv
`timescale 1ns/10ps
// Contract
// - Status reads may be framed by read strobe or by chip select.
// - Host reads status twice, compares toggle bit; steady means done.
// - Still toggling with timeout_flag high: retest; toggling means fail, write reset.
// - Host resuming after other work restarts polling from the first step.
// - After a timing failure host writes reset before new operations.
// - Host issuing sector erases within 50 us may skip erase_timer_flag.
// - Host confirms acceptance by polling, then reads erase_timer_flag.
module fwsr_host import fwsr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [FLASH_AW-1:0] flash_addr,
  output logic flash_chip_select_n,
  output logic flash_read_strobe_n,
  output logic flash_write_strobe_n,
  output logic [FLASH_DW-1:0] flash_data_out,
  output logic flash_data_oe_n,
  input wire logic [FLASH_DW-1:0] flash_data_in
);

  typedef enum logic [2:0] {
    P_IDLE, P_CMD, P_RD_FIRST, P_RD_SECOND, P_RD_THIRD, P_RD_FOURTH, P_ARRAY, P_RESET_CMD
  } fwsr_poll_t;

  // ======================================================================
  // Declarations
  logic [FLASH_AW-1:0] addr_q;
  logic [FLASH_DW-1:0] wdata_q;
  logic frame_cs_q;
  logic done_q;
  logic ok_q;
  logic fail_q;
  logic timeout_q;
  logic erase_timer_q;
  logic toggle_two_q;
  logic [FLASH_DW-1:0] rdata_q;
  logic [31:0] readdata_d;
  fwsr_poll_t state_q;
  fwsr_poll_t state_d;
  logic [FLASH_DW-1:0] first_q;
  logic [FLASH_DW-1:0] first_d;
  logic sent_q;
  logic sent_d;
  logic start_q;
  logic start_d;
  logic abort_q;
  logic fin_ok;
  logic fin_fail;
  logic fin_cmd;
  logic [FLASH_DW-1:0] data_sync;
  logic bus_done;
  logic [FLASH_DW-1:0] bus_rdata;

  // ======================================================================
  // Avalon slave decode: a write takes effect on the edge that sees
  // waitrequest low, so every access costs exactly one wait cycle
  wire bus_take = !avs_waitrequest;
  wire wr_ctrl = avs_write && bus_take && (avs_address == REG_CTRL);
  wire wr_addr = avs_write && bus_take && (avs_address == REG_ADDR);
  wire wr_wdata = avs_write && bus_take && (avs_address == REG_WDATA);
  wire go_write = wr_ctrl && avs_writedata[CTRL_GO_WRITE];
  wire go_poll = wr_ctrl && avs_writedata[CTRL_GO_POLL] && !avs_writedata[CTRL_GO_WRITE];
  wire abort = wr_ctrl && avs_writedata[CTRL_ABORT];
  // Abort is held until the running pin cycle ends, else a mid-cycle write is lost
  wire abort_req = abort || abort_q;
  wire busy = (state_q != P_IDLE);
  wire accept_go = !busy && (go_write || go_poll);
  wire [31:0] status_word = {25'h0, toggle_two_q, erase_timer_q, timeout_q, fail_q, ok_q,
                             done_q, busy};

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    case (avs_address)
      REG_CTRL: readdata_d = {29'h0, frame_cs_q, 2'b00};
      REG_ADDR: readdata_d = {13'h0, addr_q};
      REG_WDATA: readdata_d = {24'h0, wdata_q};
      REG_STATUS: readdata_d = status_word;
      REG_RDATA: readdata_d = {24'h0, rdata_q};
      default: readdata_d = RESET_WORD;
    endcase
  end

  // Waitrequest high by default, low for one cycle per request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= RESET_WORD;
    end else begin
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= readdata_d;
      end
    end
  end

  // Software-written setup registers; held while an operation runs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_q <= '0;
      wdata_q <= 8'h00;
      frame_cs_q <= 1'b0;
    end else begin
      if (wr_addr && !busy) begin
        addr_q <= avs_writedata[FLASH_AW-1:0];
      end
      if (wr_wdata && !busy) begin
        wdata_q <= avs_writedata[FLASH_DW-1:0];
      end
      if (wr_ctrl && !busy) begin
        frame_cs_q <= avs_writedata[CTRL_FRAME_CS];
      end
    end
  end

  // ======================================================================
  // Polling sequencer: each state but P_IDLE issues a pin cycle and waits for it; P_RD_SECOND repeats until toggling stops or the flag rises
  wire rd_done = sent_q && bus_done;
  wire toggling = fwsr_toggled(first_q, bus_rdata);
  wire to_flag = bus_rdata[TIMEOUT_FLAG_POS];

  always_comb begin
    state_d = state_q;
    first_d = first_q;
    sent_d = sent_q;
    start_d = 1'b0;
    fin_ok = 1'b0;
    fin_fail = 1'b0;
    fin_cmd = 1'b0;
    if (!sent_q && busy && !start_q) begin
      start_d = 1'b1;
      sent_d = 1'b1;
    end else if (rd_done) begin
      sent_d = 1'b0;
    end
    case (state_q)
      P_IDLE: begin
        // A new poll always begins at the first read
        if (go_write) begin
          state_d = P_CMD;
        end else if (go_poll && accept_go) begin
          state_d = P_RD_FIRST;
        end
      end
      P_CMD: begin
        if (rd_done) begin
          state_d = P_IDLE;
          fin_cmd = 1'b1;
        end
      end
      P_RD_FIRST: begin
        if (rd_done) begin
          first_d = bus_rdata;
          state_d = P_RD_SECOND;
        end
      end
      P_RD_SECOND: begin
        if (rd_done) begin
          if (!toggling) begin
            state_d = P_ARRAY;
          end else if (to_flag) begin
            state_d = P_RD_THIRD;
          end else begin
            // Keep monitoring: newest byte becomes the reference
            first_d = bus_rdata;
          end
        end
      end
      P_RD_THIRD: begin
        if (rd_done) begin
          first_d = bus_rdata;
          state_d = P_RD_FOURTH;
        end
      end
      P_RD_FOURTH: begin
        if (rd_done) begin
          // Toggling may stop just as the flag rises, so retest once
          state_d = toggling ? P_RESET_CMD : P_ARRAY;
        end
      end
      P_ARRAY: begin
        if (rd_done) begin
          state_d = P_IDLE;
          fin_ok = 1'b1;
        end
      end
      P_RESET_CMD: begin
        if (rd_done) begin
          state_d = P_IDLE;
          fin_fail = 1'b1;
        end
      end
      default: state_d = P_IDLE;
    endcase
    // Abort leaves polling; an unfinished pin cycle still completes
    if (abort_req && busy && state_q != P_CMD && state_q != P_RESET_CMD && !sent_d) begin
      state_d = P_IDLE;
    end
  end

  // Pending abort clears once the engine heads for idle
  wire abort_d = abort_req && busy && (state_d != P_IDLE);

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= P_IDLE;
      first_q <= 8'h00;
      sent_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
      sent_q <= sent_d;
      start_q <= start_d;
      abort_q <= abort_d;
    end
  end

  // ======================================================================
  // Result and status flags; a new request clears done, ok, fail and timeout
  wire status_read = rd_done && (state_q inside {P_RD_FIRST, P_RD_SECOND, P_RD_THIRD,
                                                  P_RD_FOURTH});

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      ok_q <= 1'b0;
      fail_q <= 1'b0;
      timeout_q <= 1'b0;
      erase_timer_q <= 1'b0;
      toggle_two_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (accept_go) begin
        done_q <= 1'b0;
        ok_q <= 1'b0;
        fail_q <= 1'b0;
        timeout_q <= 1'b0;
      end
      if (status_read) begin
        // Timer flag tells software whether more sector erases fit
        erase_timer_q <= bus_rdata[ERASE_TIMER_FLAG_POS];
        // Second toggle bit moved to the position the compare function looks at
        toggle_two_q <= fwsr_toggled({1'b0, first_q[TOGGLE_BIT_TWO_POS], 6'h00},
                                     {1'b0, bus_rdata[TOGGLE_BIT_TWO_POS], 6'h00});
        timeout_q <= timeout_q || to_flag;
      end
      if (fin_ok || fin_fail || fin_cmd) begin
        done_q <= 1'b1;
      end
      if (fin_ok) begin
        ok_q <= 1'b1;
        rdata_q <= bus_rdata;
      end
      if (fin_fail) begin
        fail_q <= 1'b1;
      end
    end
  end

  // ======================================================================
  // Pin-side blocks
  wire bus_is_write = (state_q == P_CMD) || (state_q == P_RESET_CMD);
  wire [FLASH_DW-1:0] bus_wdata = (state_q == P_RESET_CMD) ? RESET_CMD_DATA : wdata_q;

  fwsr_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(flash_data_in),
    .sync_out(data_sync)
  );

  // Status reads may use either framing the software picks
  fwsr_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(start_q),
    .is_write(bus_is_write),
    .frame_cs(frame_cs_q),
    .addr(addr_q),
    .wdata(bus_wdata),
    .data_sync(data_sync),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .flash_chip_select_n(flash_chip_select_n),
    .flash_read_strobe_n(flash_read_strobe_n),
    .flash_write_strobe_n(flash_write_strobe_n),
    .flash_data_out(flash_data_out),
    .flash_data_oe_n(flash_data_oe_n)
  );

endmodule : fwsr_host

// >>> hw/fwsr_pkg.sv
// ======================================================================
// Shared constants for the flash status polling controller
package fwsr_pkg;

  // ======================================================================
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ACC_NS = 90; // Slowest grade read access
  localparam int T_WP_NS = 35; // Write strobe low time
  localparam int T_SETUP_NS = 20; // Address/select before strobe
  localparam int SYNC_CYC = 2; // Data input synchroniser depth
  // Least times round up to whole cycles
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RD_STROBE_CNT = 4'(ACC_CYC + SYNC_CYC - 1);
  localparam logic [3:0] WR_STROBE_CNT = 4'(WP_CYC - 1);
  localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC - 1);

  // ======================================================================
  // Flash data bus and status bit positions
  localparam int FLASH_AW = 19;
  localparam int FLASH_DW = 8;
  localparam int TOGGLE_BIT_ONE_POS = 6;
  localparam int TIMEOUT_FLAG_POS = 5;
  localparam int ERASE_TIMER_FLAG_POS = 3;
  localparam int TOGGLE_BIT_TWO_POS = 2;
  localparam logic [7:0] RESET_CMD_DATA = 8'hF0;

  // ======================================================================
  // Register word indices on the Avalon slave
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA = 3'h4;

  // CTRL fields
  localparam int CTRL_GO_WRITE = 0;
  localparam int CTRL_GO_POLL = 1;
  localparam int CTRL_FRAME_CS = 2;
  localparam int CTRL_ABORT = 3;

  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_OK = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_ERASE_TIMER = 5;
  localparam int ST_TOGGLE_TWO = 6;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // True when the toggle bit differs between two status bytes
  function automatic logic fwsr_toggled(input logic [7:0] a, input logic [7:0] b);
    return a[TOGGLE_BIT_ONE_POS] ^ b[TOGGLE_BIT_ONE_POS];
  endfunction : fwsr_toggled

endpackage : fwsr_pkg

// >>> hw/fwsr_sync.sv
`timescale 1ns/10ps
// ======================================================================
// Two-stage synchroniser for the flash data bus
module fwsr_sync import fwsr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [FLASH_DW-1:0] async_in,
  output logic [FLASH_DW-1:0] sync_out
);

  logic [FLASH_DW-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : fwsr_sync

// >>> verification/fwsr_chk.sv
`timescale 1ns/10ps
// ======================================================================
// Bus and pin timing checks for the flash polling controller
module fwsr_chk import fwsr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic flash_chip_select_n,
  input wire logic flash_read_strobe_n,
  input wire logic flash_write_strobe_n,
  input wire logic flash_data_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Active high views keep the properties short
  wire cs = !flash_chip_select_n;
  wire oe = !flash_read_strobe_n;
  wire we = !flash_write_strobe_n;

  // ======================================================================
  // Avalon answer timing
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  ack_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");

  // ======================================================================
  // Flash pin framing; a write with the output enabled would corrupt the bus
  wr_inhibit_a: assert property (we |-> cs && !oe && !flash_data_oe_n)
    else $error("write strobe without select or with output enable");
  rd_no_drive_a: assert property (oe |-> flash_data_oe_n)
    else $error("host drives data while flash output enabled");
  wr_pulse_a: assert property ($rose(we) |-> we [*2] ##1 !we)
    else $error("write strobe not two cycles");
  oe_frame_a: assert property ($rose(oe) && cs |-> oe [*7] ##1 !oe)
    else $error("read strobe framed read not seven cycles");
  cs_frame_a: assert property ($rose(cs) && oe |-> cs [*7] ##1 !cs)
    else $error("select framed read not seven cycles");
  idle_gap_a: assert property ($fell(cs) |-> !cs [*2])
    else $error("select idle less than two cycles");
  addr_hold_a: assert property (cs && $past(cs) |-> $stable(flash_addr))
    else $error("address moved inside a cycle");

  cover property ($rose(cs) && oe);
  cover property ($rose(oe) && cs);
  cover property ($rose(we));
endmodule : fwsr_chk

// >>> verification/fwsr_flash_model.sv
`timescale 1ns/10ps
// ======================================================================
// Behavioural flash: status byte while busy, array byte when idle
module fwsr_flash_model import fwsr_pkg::*; (
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic flash_chip_select_n,
  input wire logic flash_read_strobe_n,
  input wire logic flash_write_strobe_n,
  input wire logic [FLASH_DW-1:0] flash_data_out,
  input wire logic flash_data_oe_n,
  output logic [FLASH_DW-1:0] flash_data_in
);
  // Set by the bench: reads left to toggle (negative never ends)
  int busy_reads = 0;
  int wr_count = 0;
  logic exceeded = 1'b0; // Raised by the bench only, never for a non-blank program
  logic lockout = 1'b0; // Supply below the lockout level
  logic timer_done = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [7:0] array_byte = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic [FLASH_AW-1:0] last_wa = '0;
  logic [7:0] dq;
  wire rd_end = flash_chip_select_n | flash_read_strobe_n;
  // Status at any address while busy; polling bit reads 0 meanwhile
  assign dq = (busy_reads != 0) ? {1'b0, t1, exceeded, 1'b0, timer_done, t2, 2'b00}
    : array_byte;
  // Released bus shows the inverse so a stale byte never passes
  assign flash_data_in = !flash_data_oe_n ? flash_data_out : (rd_end ? ~dq : dq);

  // Advance once per read, on whichever strobe ends it
  always @(posedge rd_end) begin
    if (busy_reads != 0) begin
      t1 = ~t1;
      t2 = ~t2;
      // Bounded toggling, then array read again
      if (busy_reads > 0) busy_reads = busy_reads - 1;
    end
  end

  // Writes land on the rising write strobe; reset command ends the algorithm
  always @(posedge flash_write_strobe_n) begin
    if (!lockout && !flash_chip_select_n && flash_read_strobe_n) begin
      last_wr = flash_data_out;
      last_wa = flash_addr;
      wr_count++;
      if (flash_data_out == RESET_CMD_DATA) begin
        busy_reads = 0;
        exceeded = 1'b0;
      end
    end
  end
endmodule : fwsr_flash_model

// >>> verification/fwsr_host_tb_top.sv
`timescale 1ns/10ps
// ======================================================================
// Bench for the flash status polling controller
module fwsr_host_tb_top import fwsr_pkg::*; ;
  typedef struct {string name; logic [31:0] exp; logic [31:0] msk;} fwsr_note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rdv, e;
  logic [31:0] seed = 32'h652f_bb71;
  logic avs_waitrequest, cs_n, rd_n, wr_n, oe_n;
  logic [FLASH_AW-1:0] flash_addr;
  logic [FLASH_DW-1:0] d_out, d_in, arr;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  fwsr_note_t notes[$];
  fwsr_note_t cur;

  fwsr_host fwsr_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
    .flash_chip_select_n(cs_n), .flash_read_strobe_n(rd_n), .flash_write_strobe_n(wr_n),
    .flash_data_out(d_out), .flash_data_oe_n(oe_n), .flash_data_in(d_in));
  fwsr_flash_model fwsr_flash_model_i (.flash_addr(flash_addr), .flash_chip_select_n(cs_n),
    .flash_read_strobe_n(rd_n), .flash_write_strobe_n(wr_n), .flash_data_out(d_out),
    .flash_data_oe_n(oe_n), .flash_data_in(d_in));

  always #10 sys_clk = ~sys_clk;

  function automatic logic [31:0] fwsr_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : fwsr_rand

  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : cmp

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Request held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic chk(input string n, input logic [2:0] a, input logic [31:0] x,
    input logic [31:0] m);
    notes.push_back('{n, x, m});
    bus(1'b0, a, 32'h0000_0000);
  endtask : chk

  task automatic wait_bit(input int b);
    do chk("poll", REG_STATUS, 32'h0000_0000, 32'h0000_0000);
    while (rdv[b] !== 1'b1);
  endtask : wait_bit

  task automatic run_poll(input int n, input logic to, input logic cs, input logic [7:0] a);
    fwsr_flash_model_i.busy_reads = n;
    fwsr_flash_model_i.exceeded = to;
    fwsr_flash_model_i.array_byte = a;
    bus(1'b1, REG_CTRL, {29'h0000_0000, cs, 2'b10});
    wait_bit(ST_DONE);
  endtask : run_poll

  // Oldest note meets each read answer; polling reads carry an empty mask
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.msk != 32'h0000_0000) cmp(cur.name, cur.exp & cur.msk, avs_readdata & cur.msk);
    end
  end

  // Hang guard, well above the longest expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, readback and an unmapped place
    chk("status", REG_STATUS, RESET_WORD, 32'hffff_ffff);
    chk("rdata", REG_RDATA, RESET_WORD, 32'hffff_ffff);
    seed = fwsr_rand(seed);
    bus(1'b1, 3'h6, seed);
    chk("unmapped", 3'h6, 32'h0000_0000, 32'hffff_ffff);
    bus(1'b1, REG_ADDR, seed);
    chk("addr", REG_ADDR, {13'h0000, seed[18:0]}, 32'hffff_ffff);
    $display("register test done");
    // Toggle runs of several lengths, both read framings, one with timeout high
    for (int i = 0; i < 4; i++) begin
      seed = fwsr_rand(seed);
      arr = seed[7:0] & 8'hdf;
      run_poll((i == 3) ? 2 : i * 3, i == 3, i[0], arr);
      e = 32'h0000_0006 | (32'(i == 3) << ST_TIMEOUT);
      chk("status", REG_STATUS, e, 32'h0000_001f);
      chk("rdata", REG_RDATA, {24'h00_0000, arr}, 32'h0000_00ff);
      chk("ctrl", REG_CTRL, {29'h0000_0000, i[0], 2'b00}, 32'hffff_ffff);
      cmp("writes", 32'h0000_0000, 32'(fwsr_flash_model_i.wr_count));
    end
    $display("toggle poll test done");
    // Abort of an endless poll leaves it after the running pin cycle
    fwsr_flash_model_i.busy_reads = -1;
    fwsr_flash_model_i.exceeded = 1'b0;
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    repeat (30) @(posedge sys_clk);
    bus(1'b1, REG_CTRL, 32'h0000_0008);
    do chk("poll", REG_STATUS, 32'h0000_0000, 32'h0000_0000);
    while (rdv[ST_BUSY] !== 1'b0);
    chk("abort", REG_STATUS, 32'h0000_0000, 32'h0000_001f);
    cmp("writes", 32'h0000_0000, 32'(fwsr_flash_model_i.wr_count));
    $display("abort test done");
    // Toggling never stops with timeout high: reset command must follow
    seed = fwsr_rand(seed);
    bus(1'b1, REG_ADDR, {13'h0000, seed[18:0]});
    fwsr_flash_model_i.timer_done = 1'b1;
    run_poll(-1, 1'b1, 1'b0, 8'h00);
    chk("status", REG_STATUS, 32'h0000_007a, 32'h0000_007f);
    cmp("reset data", 32'(RESET_CMD_DATA), 32'(fwsr_flash_model_i.last_wr));
    cmp("reset addr", 32'(seed[18:0]), 32'(fwsr_flash_model_i.last_wa));
    $display("timeout test done");
    // One byte write refused under supply lockout, then one that lands
    seed = fwsr_rand(seed);
    bus(1'b1, REG_ADDR, {13'h0000, seed[18:0]});
    bus(1'b1, REG_WDATA, {24'h00_0000, seed[26:19]});
    chk("wdata", REG_WDATA, {24'h00_0000, seed[26:19]}, 32'hffff_ffff);
    for (int k = 0; k < 2; k++) begin
      fwsr_flash_model_i.lockout = (k == 0);
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      wait_bit(ST_DONE);
      cmp("writes", 32'(k + 1), 32'(fwsr_flash_model_i.wr_count));
    end
    cmp("write data", 32'(seed[26:19]), 32'(fwsr_flash_model_i.last_wr));
    cmp("write addr", 32'(seed[18:0]), 32'(fwsr_flash_model_i.last_wa));
    $display("write test done");
    @(posedge sys_clk);
    final_report();
  end
endmodule : fwsr_host_tb_top

bind fwsr_host fwsr_chk fwsr_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
  .flash_chip_select_n(flash_chip_select_n), .flash_read_strobe_n(flash_read_strobe_n),
  .flash_write_strobe_n(flash_write_strobe_n), .flash_data_oe_n(flash_data_oe_n));
